/* File: core/rds_reset_sequencer.sv */
// Purpose: merge reset requests, hold a reset latch, time its release
// Assumes: sys_rst is the power-on event; requests are asynchronous levels
// Notes:   long counts are parameters so simulation can shorten them
module rds_reset_sequencer
	import rds_pkg::*;
#(
	parameter int POR_TICK   = rds_pkg::POR_TICK_CYC,
	parameter int P_0P25     = rds_pkg::PERIOD_0P25_CYC,
	parameter int P_18       = rds_pkg::PERIOD_18_CYC,
	parameter int P_60       = rds_pkg::PERIOD_60_CYC,
	parameter int P_1S       = rds_pkg::PERIOD_1S_CYC
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	// asynchronous reset requests
	input  wire logic        externalResetPin_n,
	input  wire logic        brownOutReq,
	input  wire logic        watchdogReq,
	// fuse and power-down state
	input  wire logic [1:0]  extendedFuseWord,
	input  wire logic        fuseProgrammed,
	input  wire logic        powerDown,
	// results
	output logic             internalReset,
	output logic             pcLoad,
	output logic [11:0]      pcLoadAddr,
	output logic             wakeUp,
	output rds_pkg::rds_src_t resetCause
);
	import rds_pkg::*;

	localparam int CW = 27;

	initial begin
		if (POR_TICK < 1 || P_0P25 < 1 || P_18 < 1 || P_60 < 1 || P_1S < 1)
			$error("rds_reset_sequencer: counts must be at least one cycle");
		if (P_1S >= (1 << CW) || POR_TICK * TICKS_FULL >= (1 << CW))
			$error("rds_reset_sequencer: count wider than timer prescaler");
	end

	typedef enum logic [1:0] {
		RDS_ST_HOLD,
		RDS_ST_COUNT,
		RDS_ST_RUN
	} rds_state_t;

	// fuse code picks period
	// selected period in cycles for a fuse code
	function automatic logic [CW-1:0] periodCycles(input logic [1:0] code);
		case (code)
			RDS_FUSE_250US: periodCycles = CW'(P_0P25);
			RDS_FUSE_18MS:  periodCycles = CW'(P_18);
			RDS_FUSE_60MS:  periodCycles = CW'(P_60);
			RDS_FUSE_1S:    periodCycles = CW'(P_1S);
			default:        periodCycles = CW'(P_18);
		endcase
	endfunction

	logic [2:0]            reqSync;
	logic                  pinHigh;
	logic                  borActive;
	logic                  wdtActive;
	logic [1:0]            fuseSel;
	logic [CW-1:0]         limit;
	rds_state_t            state_q;
	logic                  porSeq_q;
	logic [CW-1:0]         pre_q;
	logic [TIMER_BITS-1:0] ripple_q;
	logic                  expired;
	logic                  anyReq;
	logic                  borSeen_q;

	// pin and detectors cross into the clock domain
	rds_sync #(.WIDTH(3), .RST_VAL(32'h0)) uSync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.asyncIn  ({externalResetPin_n, brownOutReq, watchdogReq}),
		.syncOut  (reqSync)
	);
	assign pinHigh   = reqSync[2];
	assign borActive = reqSync[1];
	assign wdtActive = reqSync[0];

	assign fuseSel = fuseProgrammed ? extendedFuseWord : FUSE_DEFAULT;

	// the full ripple count belongs to power-on only; others use fuse period
	assign limit   = porSeq_q ? CW'(POR_TICK) : periodCycles(fuseSel);
	// ripple carry out of the 10-bit timer marks expiry on power-on
	assign expired = porSeq_q ? (&ripple_q && pre_q == limit - CW'(1))
	                          : (pre_q == limit - CW'(1));

	// brown-out followed by recovery is a request; the low pin is too
	assign anyReq = !pinHigh || wdtActive || (borSeen_q && !borActive);

	// remember a brown-out until the supply has recovered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			borSeen_q <= 1'b0;
		end else if (clkEn) begin
			if (borActive)
				borSeen_q <= 1'b1;
			else if (state_q == RDS_ST_HOLD)
				borSeen_q <= 1'b0;
		end
	end

	// sequencer; a request always restarts the hold, timer or not
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q  <= RDS_ST_HOLD;
			porSeq_q <= 1'b1;
		end else if (clkEn) begin
			case (state_q)
				RDS_ST_HOLD: begin
					// count only once the pin reads high
					if (pinHigh && !wdtActive && !borActive)
						state_q <= RDS_ST_COUNT;
				end
				RDS_ST_COUNT: begin
					if (anyReq || borActive)
						state_q <= RDS_ST_HOLD;
					else if (expired) begin
						state_q  <= RDS_ST_RUN;
						porSeq_q <= 1'b0;
					end
				end
				RDS_ST_RUN: begin
					if (anyReq || borActive)
						state_q <= RDS_ST_HOLD;
				end
				default: state_q <= RDS_ST_HOLD;
			endcase
		end
	end

	// ripple count runs from the start condition only; the prescaler also runs in power-down
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_q    <= '0;
			ripple_q <= '0;
		end else if (clkEn) begin
			if (state_q == RDS_ST_COUNT && !anyReq && !borActive) begin
				if (pre_q == limit - CW'(1)) begin
					pre_q    <= '0;
					ripple_q <= ripple_q + TIMER_BITS'(1);
				end else begin
					pre_q <= pre_q + CW'(1);
				end
			end else if (state_q == RDS_ST_RUN && powerDown) begin
				// fuse period counts while powered down
				pre_q    <= expired ? '0 : pre_q + CW'(1);
				ripple_q <= '0;
			end else begin
				pre_q    <= '0;
				ripple_q <= '0;
			end
		end
	end

	// internal reset registered from the latch state or any live request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			internalReset <= 1'b1;
		else if (clkEn)
			internalReset <= (state_q != RDS_ST_RUN) || anyReq || borActive;
	end

	// wake pulse on expiry in power-down
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			wakeUp <= 1'b0;
		else if (clkEn)
			wakeUp <= state_q == RDS_ST_RUN && powerDown && expired && !anyReq;
		else
			wakeUp <= 1'b0;
	end

	// load top address while any reset holds; record the cause
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcLoad     <= 1'b1;
			pcLoadAddr <= PC_TOP_ADDR;
			resetCause <= RDS_SRC_POR;
		end else if (clkEn) begin
			pcLoadAddr <= PC_TOP_ADDR;
			pcLoad     <= (state_q != RDS_ST_RUN) || anyReq || borActive;
			if (state_q == RDS_ST_RUN) begin
				if (borActive)
					resetCause <= RDS_SRC_BOR;
				else if (wdtActive)
					resetCause <= RDS_SRC_WDT;
				else if (!pinHigh)
					resetCause <= RDS_SRC_EXT;
				else if (powerDown && expired)
					resetCause <= RDS_SRC_WAKE;
			end
		end
	end
endmodule

/* File: shared/rds_pkg.sv */
// Purpose: constants and types shared by the reset delay sequencer
// Assumes: 125 MHz system clock; times kept in microseconds
// Notes:   cycle counts derive from the times below
// How it works
// - any valid reset loads program counter with top program address 0FFF.
// - a 10-bit delay reset timer sets how long reset lasts.
// - internal reset comes straight from a reset latch; here it is registered from the latch state or any live request.
// - the reset latch is set at power-up.
// - delay timer waits for external reset pin high before counting.
// - timer expiry clears the latch, typically 72 msec after power-up.
// - timer period sets the reset timeout after the start condition.
// - brown-out followed by recovery puts the device into reset.
// - full 10-bit ripple count used only for power-on reset.
// - fuse 10=0.25ms, 11=18ms, 00=60ms, 01=1s timer period.
// - unprogrammed fuse field reads 11, giving 18 msec.
// - in power-down, expiry of selected period wakes the device.
package rds_pkg;
	localparam int CLK_MHZ        = 125;
	localparam int TIMER_BITS     = 10;
	localparam logic [11:0] PC_TOP_ADDR = 12'hFFF;
	localparam int POR_TIME_US    = 72000;
	localparam int T_0P25_US      = 250;
	localparam int T_18_US        = 18000;
	localparam int T_60_US        = 60000;
	localparam int T_1S_US        = 1000000;
	// one timer tick lasts the period divided by the full 10-bit count
	localparam int TICKS_FULL     = 1 << TIMER_BITS;
	localparam int POR_TICK_CYC   = (POR_TIME_US * CLK_MHZ) / TICKS_FULL;
	localparam int PERIOD_0P25_CYC = T_0P25_US * CLK_MHZ;
	localparam int PERIOD_18_CYC  = T_18_US * CLK_MHZ;
	localparam int PERIOD_60_CYC  = T_60_US * CLK_MHZ;
	localparam int PERIOD_1S_CYC  = T_1S_US * CLK_MHZ;
	localparam logic [1:0] FUSE_DEFAULT = 2'h3;
	localparam int SYNC_STAGES    = 2;

	typedef enum logic [1:0] {
		RDS_FUSE_60MS  = 2'h0,
		RDS_FUSE_1S    = 2'h1,
		RDS_FUSE_250US = 2'h2,
		RDS_FUSE_18MS  = 2'h3
	} rds_fuse_t;

	typedef enum logic [2:0] {
		RDS_SRC_NONE = 3'h0,
		RDS_SRC_POR  = 3'h1,
		RDS_SRC_BOR  = 3'h2,
		RDS_SRC_WDT  = 3'h3,
		RDS_SRC_EXT  = 3'h4,
		RDS_SRC_WAKE = 3'h5
	} rds_src_t;
endpackage

/* File: core/rds_sync.sv */
// Purpose: two-stage synchroniser for a bundle of asynchronous levels
// Assumes: inputs are slow levels; stage one feeds only stage two
// Notes:   reset value is a parameter; at zero, active-high requests start deasserted
module rds_sync #(
	parameter int   WIDTH   = 4,
	parameter logic [31:0] RST_VAL = 32'h0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             clkEn,
	// levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1 || WIDTH > 32) $error("rds_sync: WIDTH out of range");
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q  <= RST_VAL[WIDTH-1:0];
			syncOut <= RST_VAL[WIDTH-1:0];
		end else if (clkEn) begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule

/* File: tb/rds_seq_monitor.sv */
// Purpose: port checks for the reset sequencer
// Assumes: one clock, sys_rst asynchronous and active high
// Notes:   shortest simulated fuse period is 3 cycles
module rds_seq_monitor
	import rds_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              clkEn,
	// requests
	input wire logic              externalResetPin_n,
	input wire logic              brownOutReq,
	input wire logic              watchdogReq,
	// results
	input wire logic              internalReset,
	input wire logic              pcLoad,
	input wire logic [11:0]       pcLoadAddr,
	input wire logic              wakeUp,
	input wire rds_pkg::rds_src_t resetCause
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_pc_top_addr: assert property (pcLoad |-> pcLoadAddr == PC_TOP_ADDR)
		else $error("pc load address is not the top");
	a_pc_follows_latch: assert property (pcLoad == internalReset)
		else $error("pc load differs from internal reset");
	a_por_latch_set: assert property ($fell(sys_rst) |->
		internalReset && resetCause == RDS_SRC_POR)
		else $error("latch not set after power-on");
	a_release_needs_pin: assert property ($fell(internalReset) |-> $past(externalResetPin_n, 3))
		else $error("released without pin high");
	a_pin_enters_reset: assert property ((!externalResetPin_n && clkEn)[*5] |-> internalReset)
		else $error("pin request ignored");
	a_bor_enters_reset: assert property ((brownOutReq && clkEn)[*5] |-> internalReset)
		else $error("brown-out ignored");
	a_wdt_enters_reset: assert property ((watchdogReq && clkEn)[*5] |-> internalReset)
		else $error("watchdog ignored");
	a_wake_pulse_gap: assert property (wakeUp |=> !wakeUp[*2])
		else $error("wake pulses too close");
	a_freeze_hold: assert property (!clkEn |=> $stable(internalReset) && $stable(resetCause))
		else $error("state moved while clock enable low");
endmodule

bind rds_reset_sequencer rds_seq_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
	.externalResetPin_n(externalResetPin_n), .brownOutReq(brownOutReq),
	.watchdogReq(watchdogReq), .internalReset(internalReset), .pcLoad(pcLoad),
	.pcLoadAddr(pcLoadAddr), .wakeUp(wakeUp), .resetCause(resetCause));

/* File: tb/rds_far_side.sv */
// Purpose: model of the reset pin and supply detectors
// Assumes: commands change just after a rising edge
// Notes:   pin has a pull-up, so it idles high
module rds_far_side (
	// clock
	input wire logic clk,
	// commands from the bench
	input wire logic holdPin,
	input wire logic dipSupply,
	input wire logic fireDog,
	// detector levels
	output logic     externalResetPin_n,
	output logic     brownOutReq,
	output logic     watchdogReq
);
	timeunit 1ns;
	timeprecision 1ps;
	// one cycle late, like a slow analog path
	always_ff @(posedge clk) begin
		externalResetPin_n <= !holdPin;
		brownOutReq <= dipSupply;
		watchdogReq <= fireDog;
	end
endmodule

/* File: tb/test_reset_delay_sequencer.sv */
// Purpose: self-checking bench for the reset sequencer
// Assumes: POR_TICK=2, fuse periods 3/5/7/9 cycles
// Notes:   release times are checked within a 12-cycle window
module test_reset_delay_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import rds_pkg::*;
	typedef struct {logic [2:0] cause; int at;} rds_note_t;
	logic        clk = 0, sys_rst = 1, powerDown = 0, fuseProg = 1, prevRst = 1;
	logic [1:0]  fuse = 2'h3;
	logic        clkEn = 1'b1;
	logic        holdPin = 1, dipSupply = 0, fireDog = 0;
	logic        internalReset, pcLoad, wakeUp, pinN, bor, wdt;
	logic [11:0] pcLoadAddr;
	rds_src_t    resetCause;
	logic [31:0] seed = 32'h89ADA67C;
	int          cyc = 0, fails = 0, checked = 0, lastWake = -1, src;
	int          per[5] = '{7, 9, 3, 5, 5};
	rds_src_t    cz[3] = '{RDS_SRC_WDT, RDS_SRC_BOR, RDS_SRC_EXT};
	rds_note_t   n, notes[$];
	always #4 clk = !clk;
	rds_far_side u_far (.clk(clk), .holdPin(holdPin), .dipSupply(dipSupply), .fireDog(fireDog),
		.externalResetPin_n(pinN), .brownOutReq(bor), .watchdogReq(wdt));
	rds_reset_sequencer #(.POR_TICK(2), .P_0P25(3), .P_18(5), .P_60(7), .P_1S(9)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .externalResetPin_n(pinN),
		.brownOutReq(bor), .watchdogReq(wdt), .extendedFuseWord(fuse),
		.fuseProgrammed(fuseProg), .powerDown(powerDown), .internalReset(internalReset),
		.pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .wakeUp(wakeUp), .resetCause(resetCause));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// bounded wait for the latch to clear
	task automatic waitRel();
		for (int i = 0; i < 3000 && internalReset !== 1'b0; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
	endtask
	// cycle count doubles as the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	// each release or later wake pulse consumes the oldest note
	always @(posedge clk) begin
		prevRst <= internalReset;
		if (prevRst === 1'b1 && internalReset === 1'b0) begin
			n = notes.pop_front();
			chk("release cause", 12'(resetCause), 12'(n.cause));
			chk("release time", 12'(cyc >= n.at && cyc <= n.at + 12), 12'h1);
		end
		if (wakeUp === 1'b1) begin
			if (lastWake >= 0 && notes.size() > 0) begin
				n = notes.pop_front();
				chk("wake spacing", 12'(cyc - lastWake), 12'(n.at));
				chk("wake cause", 12'(resetCause), 12'(RDS_SRC_WAKE));
			end
			lastWake = cyc;
		end
	end
	// power-on, then each fuse code with a rotating reset source
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		repeat (5) @(posedge clk);
		holdPin <= 0;
		// full count only after pin high
		notes.push_back('{RDS_SRC_POR, cyc + 2048});
		waitRel();
		for (int k = 0; k < 5; k++) begin
			fuseProg <= (k != 4);
			fuse <= 2'(k);
			seed = xs(seed);
			src = k % 3;
			fireDog <= (src == 0);
			dipSupply <= (src == 1);
			holdPin <= (src == 2);
			repeat (6) @(posedge clk);
			// freeze only after entry has been seen, so release timing is unaffected
			clkEn <= 1'b0;
			repeat (1 + seed[2:0]) @(posedge clk);
			clkEn <= 1'b1;
			fireDog <= 0;
			dipSupply <= 0;
			holdPin <= 0;
			notes.push_back('{cz[src], cyc + per[k]});
			waitRel();
		end
		fuse <= 2'h0;
		fuseProg <= 1'b1;
		powerDown <= 1;
		repeat (3) notes.push_back('{RDS_SRC_WAKE, 7});
		for (int i = 0; i < 100 && notes.size() > 0; i++)
			@(posedge clk);
		chk("wake count", 12'(notes.size()), 12'h0);
		powerDown <= 0;
		give_verdict();
	end
endmodule
